// [common/wdog_consts.svh]
`ifndef WDOG_CONSTS_SVH
`define WDOG_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register map (index times four is the byte address)
// ----------------------------------------------------------------------------
`define WDOG_IDX_CTRL 6'h0a
`define WDOG_IDX_EVT_STATUS 6'h0b
`define WDOG_IDX_EVT_MASK 6'h0c
`define WDOG_CTRL_RESET 8'h00
`define WDOG_EVT_RESET 2'h0
// ----------------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------------
`define WDOG_BIT_RESTART 5
`define WDOG_BIT_RST_EN 4
`define WDOG_BIT_IRQ_EN 3
`define WDOG_BIT_CYC_EN 2
`define WDOG_BIT_FLAG 1
`define WDOG_BIT_RATE 0
// Event status and mask positions.
`define WDOG_EVT_TIMEOUT 0
`define WDOG_EVT_HALL 1
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDOG_CLK_KHZ 10000
`define WDOG_FAST_MS 10
`define WDOG_SLOW_MS 20
`define WDOG_SETTLE_NS 400
`define WDOG_CLK_NS 100
`define WDOG_SETTLE_CYCLES ((`WDOG_SETTLE_NS + `WDOG_CLK_NS - 1) / `WDOG_CLK_NS)
`define WDOG_RST_PULSE_CYCLES 16
`endif

// [common/wdog_pkg.sv]
package wdog_pkg;
    typedef logic [2:0] hall_mask_t;
    typedef logic [17:0] wdog_count_t;
    typedef enum logic [0:0] {CHECK_IDLE, CHECK_POWER} check_state_t;
endpackage : wdog_pkg

// [design/autonomous_watchdog_ctrl.sv]
`timescale 1ns/1ps
`include "wdog_consts.svh"

module autonomous_watchdog_ctrl #(
    parameter int FAST_TICKS = `WDOG_FAST_MS * `WDOG_CLK_KHZ,
    parameter int SLOW_TICKS = `WDOG_SLOW_MS * `WDOG_CLK_KHZ
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // System mode and sensing pins
    input wire logic stop_mode_in,
    input wire wdog_pkg::hall_mask_t hall_sense_in,
    // Sensor configuration from on-chip logic
    input wire wdog_pkg::hall_mask_t hall_select_in,
    input wire logic hall_irq_enable_in,
    // Outputs toward the processor and the sensors
    output logic system_reset_out,
    output logic wake_irq_out,
    output logic irq_out,
    output logic osc_run_out,
    output wdog_pkg::hall_mask_t hall_power_out,
    output logic analog_check_out
);
    import wdog_pkg::*;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic stop_meta;
    logic stop_q;
    hall_mask_t hall_meta;
    hall_mask_t hall_q;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            stop_meta <= 1'b0;
            stop_q <= 1'b0;
            hall_meta <= 3'h0;
            hall_q <= 3'h0;
        end
        else
        begin
            stop_meta <= stop_mode_in;
            stop_q <= stop_meta;
            hall_meta <= hall_sense_in;
            hall_q <= hall_meta;
        end
    end

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    // Every access is answered on the second edge; unmapped reads return zero.
    wire req = avs_read_in | avs_write_in;
    wire wr_fire = avs_write_in & ~avs_waitrequest_out;
    wire rd_load = avs_read_in & avs_waitrequest_out;
    wire [5:0] idx = avs_address_in[7:2];
    wire hit_ctrl = (idx == `WDOG_IDX_CTRL);
    wire hit_status = (idx == `WDOG_IDX_EVT_STATUS);
    wire hit_mask = (idx == `WDOG_IDX_EVT_MASK);
    wire wr_ctrl = wr_fire & hit_ctrl;
    wire [7:0] wbyte = avs_writedata_in[7:0];

    // ------------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------------
    logic rst_en;
    logic irq_en;
    logic cyc_en;
    logic flag;
    logic rate;
    logic [1:0] evt_status;
    logic [1:0] evt_mask;
    wdog_count_t cnt;

    wire osc_en = rst_en | irq_en | cyc_en;
    wire wdog_count_t limit = rate ? wdog_count_t'(FAST_TICKS - 1)
                                   : wdog_count_t'(SLOW_TICKS - 1);
    wire tick = osc_en & (cnt >= limit);
    wire restart_wr = wr_ctrl & wbyte[`WDOG_BIT_RESTART];
    wire flag_clr = wr_ctrl & wbyte[`WDOG_BIT_FLAG];
    wire restart = restart_wr | flag_clr;
    wire wdog_count_t next_cnt = (!osc_en || restart || tick) ? '0
                                                               : cnt + 18'h1;
    wire next_flag = tick | (flag & ~flag_clr);
    wire next_rst_en = rst_en | (wr_ctrl & wbyte[`WDOG_BIT_RST_EN]);
    // The readback never shows the restart bit or the two top bits.
    wire [7:0] ctrl_view = {2'b00, 1'b0, rst_en, irq_en, cyc_en, flag, rate};

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            {rst_en, irq_en, cyc_en, flag, rate} <= 5'h00;
            cnt <= '0;
        end
        else
        begin
            cnt <= next_cnt;
            flag <= next_flag;
            rst_en <= next_rst_en;
            if (wr_ctrl)
            begin
                irq_en <= wbyte[`WDOG_BIT_IRQ_EN];
                cyc_en <= wbyte[`WDOG_BIT_CYC_EN];
                rate <= wbyte[`WDOG_BIT_RATE];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Cyclic check of the Hall and analog inputs
    // ------------------------------------------------------------------------
    // The sensors are only powered for a short window to save STOP current.
    check_state_t chk_state;
    logic [3:0] chk_cnt;
    logic hall_wake;
    wire chk_start = cyc_en & stop_q & tick;
    wire chk_done = (chk_state == CHECK_POWER) && (chk_cnt == 4'(`WDOG_SETTLE_CYCLES - 1));
    wire hall_hit = chk_done & hall_irq_enable_in & |(hall_q & hall_select_in);
    wire next_hall_wake = hall_hit | (hall_wake & stop_q);
    check_state_t next_chk_state;

    always_comb
    begin
        next_chk_state = chk_state;
        unique case (chk_state)
            CHECK_IDLE:
            begin
                if (chk_start)
                    next_chk_state = CHECK_POWER;
            end
            CHECK_POWER:
            begin
                if (chk_done || !stop_q || !cyc_en)
                    next_chk_state = CHECK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            chk_state <= CHECK_IDLE;
            chk_cnt <= 4'h0;
            hall_wake <= 1'b0;
        end
        else
        begin
            chk_state <= next_chk_state;
            chk_cnt <= (chk_state == CHECK_POWER) ? chk_cnt + 4'h1 : 4'h0;
            hall_wake <= next_hall_wake;
        end
    end

    // ------------------------------------------------------------------------
    // Reset and wake outputs
    // ------------------------------------------------------------------------
    logic [4:0] rst_cnt;
    // STOP simply masks the reset path, so RUN resumes with the same counter.
    wire rst_fire = tick & rst_en & ~stop_q;
    wire [4:0] next_rst_cnt = rst_fire ? 5'(`WDOG_RST_PULSE_CYCLES)
                                       : (rst_cnt != 5'h0) ? rst_cnt - 5'h1 : 5'h0;
    wire next_wake = stop_q & ((flag & irq_en) | hall_wake);
    wire [1:0] evt_set = {hall_hit, tick};
    wire [1:0] evt_clr = (wr_fire & hit_status) ? avs_writedata_in[1:0] : 2'h0;
    wire [1:0] next_status = evt_set | (evt_status & ~evt_clr);
    wire next_irq = |(next_status & evt_mask);
    wire [31:0] next_rdata = hit_ctrl ? {24'h0, ctrl_view}
                           : hit_status ? {30'h0, evt_status}
                           : hit_mask ? {30'h0, evt_mask} : 32'h0;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rst_cnt <= 5'h0;
            system_reset_out <= 1'b0;
            wake_irq_out <= 1'b0;
            evt_status <= `WDOG_EVT_RESET;
            evt_mask <= `WDOG_EVT_RESET;
            irq_out <= 1'b0;
            osc_run_out <= 1'b0;
            hall_power_out <= 3'h0;
            analog_check_out <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0;
        end
        else
        begin
            rst_cnt <= next_rst_cnt;
            system_reset_out <= (next_rst_cnt != 5'h0);
            wake_irq_out <= next_wake;
            evt_status <= next_status;
            if (wr_fire && hit_mask)
                evt_mask <= avs_writedata_in[1:0];
            irq_out <= next_irq;
            osc_run_out <= osc_en;
            hall_power_out <= (next_chk_state == CHECK_POWER) ? hall_select_in : 3'h0;
            analog_check_out <= (next_chk_state == CHECK_POWER);
            avs_waitrequest_out <= ~(req & avs_waitrequest_out);
            if (rd_load)
                avs_readdata_out <= next_rdata;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    restart_clears_cnt_a: assert property (restart_wr |=> cnt == '0)
        else $error("restart write did not clear the counter");
    restart_reads_zero_a: assert property (rd_load && hit_ctrl |=> !avs_readdata_out[5])
        else $error("restart bit read back as one");
    timeout_reset_fires_a: assert property (rst_fire
        |=> system_reset_out && rst_cnt == 5'(`WDOG_RST_PULSE_CYCLES))
        else $error("timeout with reset enable gave no reset pulse");
    no_reset_in_stop_a: assert property ($rose(system_reset_out) |-> $past(!stop_q))
        else $error("reset issued in stop mode");
    reset_enable_lock_a: assert property ($past(rst_en) |-> rst_en)
        else $error("reset enable was cleared by software");
    wake_needs_cause_a: assert property (wake_irq_out |-> $past(irq_en && flag || hall_wake))
        else $error("wake request without an enabled cause");
    wake_stop_only_a: assert property (wake_irq_out |-> $past(stop_q))
        else $error("wake request outside stop mode");
    power_needs_cyclic_a: assert property (|hall_power_out |-> $past(cyc_en && stop_q))
        else $error("sensors powered without cyclic check");
    flag_on_timeout_a: assert property (tick |=> flag)
        else $error("timeout did not set the flag");
    flag_clear_a: assert property (flag_clr && !tick |=> !flag)
        else $error("flag survived a write of one");
    flag_clear_restart_a: assert property (flag_clr |=> cnt == '0)
        else $error("flag clear did not restart the counter");
    period_end_a: assert property (tick |-> cnt >= (rate ? 18'(FAST_TICKS - 1)
                                                        : 18'(SLOW_TICKS - 1)))
        else $error("timeout before the selected period");
    top_bits_zero_a: assert property (rd_load |=> avs_readdata_out[31:5] == 27'h0 || !hit_ctrl)
        else $error("reserved control bits read nonzero");
    osc_gated_a: assert property (!(rst_en || irq_en || cyc_en) |=> !osc_run_out ##0 cnt == '0)
        else $error("oscillator ran with all enables clear");

    // ------------------------------------------------------------------------
    // Bus handshake checks
    // ------------------------------------------------------------------------
    // Only the slave half of the handshake is checked; the master may hold a
    // request for as long as it likes.
    wait_answers_req_a: assert property ((avs_read_in || avs_write_in)
        && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus request was not answered on the next edge");
    wait_one_cycle_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest stayed low for more than one cycle");
    unmapped_reads_zero_a: assert property (
        rd_load && !(hit_ctrl || hit_status || hit_mask) |=> avs_readdata_out == 32'h0)
        else $error("unmapped read returned nonzero data");

    // ------------------------------------------------------------------------
    // Counter, flag and event checks
    // ------------------------------------------------------------------------
    // A rate change takes effect at once, so a count already past the new end
    // value times out on the next edge instead of running a full period.
    count_advances_a: assert property (osc_en && !restart && !tick
        |=> cnt == $past(cnt) + 18'h1)
        else $error("counter skipped or stalled while running");
    flag_holds_a: assert property (flag && !flag_clr |=> flag)
        else $error("timeout flag lost without a write of one");
    timeout_event_a: assert property (tick |=> evt_status[`WDOG_EVT_TIMEOUT])
        else $error("timeout did not set its event bit");
    event_irq_level_a: assert property ($stable(evt_mask)
        |-> irq_out == |(evt_status & evt_mask))
        else $error("event interrupt does not follow status and mask");
    osc_follows_a: assert property (osc_run_out == $past(osc_en))
        else $error("oscillator output does not follow the enables");
    reset_enable_set_a: assert property (wr_ctrl && wbyte[`WDOG_BIT_RST_EN] |=> rst_en)
        else $error("reset enable write did not take");
    rate_holds_a: assert property (!wr_ctrl |=> $stable(rate))
        else $error("rate changed without a control write");
    irq_enable_gates_a: assert property (!irq_en && !hall_wake |=> !wake_irq_out)
        else $error("wake request with interrupt enable clear");

    // ------------------------------------------------------------------------
    // Reset pulse checks
    // ------------------------------------------------------------------------
    // The pulse length is held in rst_cnt rather than spelled out as a long
    // repetition, which keeps the properties cheap to evaluate.
    reset_level_a: assert property (system_reset_out == (rst_cnt != 5'h0))
        else $error("reset output does not match its pulse counter");
    reset_countdown_a: assert property (rst_cnt != 5'h0 && !rst_fire
        |=> rst_cnt == $past(rst_cnt) - 5'h1)
        else $error("reset pulse counter did not count down");
    reset_needs_enable_a: assert property ($rose(system_reset_out)
        |-> $past(rst_en && tick))
        else $error("reset pulse without an enabled timeout");

    // ------------------------------------------------------------------------
    // Cyclic check window checks
    // ------------------------------------------------------------------------
    window_length_a: assert property (chk_state == CHECK_POWER
        |-> chk_cnt <= 4'(`WDOG_SETTLE_CYCLES - 1))
        else $error("sensor window ran past its settle time");
    window_needs_tick_a: assert property ($rose(analog_check_out)
        |-> $past(cyc_en && stop_q && tick))
        else $error("sensor window opened without a timeout in stop");
    cyc_off_no_window_a: assert property (!cyc_en && chk_state == CHECK_IDLE
        |=> !analog_check_out)
        else $error("sensor window opened with cyclic check clear");
    hall_wake_clears_a: assert property (hall_wake && !stop_q && !hall_hit
        |=> !hall_wake)
        else $error("hall wake latch survived the return to run mode");
    hall_wake_irq_a: assert property (hall_wake && stop_q |=> wake_irq_out)
        else $error("hall wake did not raise the wake request");
endmodule : autonomous_watchdog_ctrl

// [verification/mcu_core_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Processor core as seen from the watchdog
// ----------------------------------------------------------------------------
module mcu_core_model (
    // Clock
    input wire logic clk_in,
    // Lines from the watchdog
    input wire logic system_reset_in,
    input wire logic wake_irq_in,
    // Mode request from the test sequence
    input wire logic stop_req_in,
    // Mode pin and event counts
    output logic stop_mode_out,
    output int n_reset_out,
    output int n_wake_out
);
    logic rst_q = 1'b0;
    logic wake_q = 1'b0;
    initial stop_mode_out = 1'b0;
    initial n_reset_out = 0;
    initial n_wake_out = 0;
    // A system reset always brings the core back to RUN, whatever software asked.
    always @(posedge clk_in)
    begin
        stop_mode_out <= stop_req_in && (system_reset_in !== 1'b1);
        rst_q <= system_reset_in;
        wake_q <= wake_irq_in;
        if (system_reset_in === 1'b1 && rst_q !== 1'b1)
            n_reset_out <= n_reset_out + 1;
        if (wake_irq_in === 1'b1 && wake_q !== 1'b1)
            n_wake_out <= n_wake_out + 1;
    end
endmodule : mcu_core_model

// [verification/autonomous_watchdog_ctrl_tb_top.sv]
`timescale 1ns/1ps
module autonomous_watchdog_ctrl_tb_top;
    import wdog_pkg::*;
    localparam logic [7:0] CTRL = 8'h28;
    localparam logic [7:0] EVS = 8'h2c;
    localparam logic [7:0] EVM = 8'h30;
    logic clk_in, resetn_in, avs_read, avs_write, waitreq, stop_req, stop_mode, hall_ie;
    logic sys_rst, wake, irq, osc, an_chk, an_q;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, rdata, q;
    hall_mask_t hall_sense, hall_sel, hall_pwr;
    int n_mismatch = 0;
    int checks = 0;
    int n_check = 0;
    int n_reset, n_wake;
    // Short periods keep the run brief; expectations use the same figures.
    autonomous_watchdog_ctrl #(.FAST_TICKS(40), .SLOW_TICKS(80)) dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address),
        .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .stop_mode_in(stop_mode),
        .hall_sense_in(hall_sense), .hall_select_in(hall_sel), .hall_irq_enable_in(hall_ie),
        .system_reset_out(sys_rst), .wake_irq_out(wake), .irq_out(irq), .osc_run_out(osc),
        .hall_power_out(hall_pwr), .analog_check_out(an_chk));
    mcu_core_model partner (.clk_in(clk_in), .system_reset_in(sys_rst), .wake_irq_in(wake),
        .stop_req_in(stop_req), .stop_mode_out(stop_mode), .n_reset_out(n_reset),
        .n_wake_out(n_wake));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cyc
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (waitreq !== 1'b0);
        chk(waitreq, 0);
        chk(n, 2);
        q = rdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(0, a, 0);
        chk(q, e);
    endtask : rdchk
    task complete_run;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        an_q <= an_chk;
        if (an_chk === 1'b1 && an_q !== 1'b1)
            n_check++;
        if (an_chk === 1'b1)
            chk(hall_pwr, hall_sel);
    end
    // The whole sequence needs about 720 cycles.
    initial
    begin
        cyc(20000);
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        resetn_in = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        stop_req = 1'b0;
        hall_sense = 3'h0;
        hall_sel = 3'h0;
        hall_ie = 1'b0;
        cyc(16);
        resetn_in <= 1'b1;
        rdchk(CTRL, 32'h0);
        chk(osc, 0);
        bus(1, CTRL, 32'he9);
        rdchk(CTRL, 32'h09);
        chk(osc, 1);
        cyc(50);
        rdchk(CTRL, 32'h0b);
        chk(wake, 0);
        chk(irq, 0);
        bus(1, CTRL, 32'h09);
        rdchk(CTRL, 32'h0b);
        bus(1, CTRL, 32'h0b);
        rdchk(CTRL, 32'h09);
        cyc(25);
        rdchk(CTRL, 32'h09);
        bus(1, CTRL, 32'h29);
        cyc(25);
        rdchk(CTRL, 32'h09);
        cyc(20);
        rdchk(CTRL, 32'h0b);
        bus(1, CTRL, 32'h0a);
        cyc(50);
        rdchk(CTRL, 32'h08);
        cyc(40);
        rdchk(CTRL, 32'h0a);
        bus(1, EVM, 32'h3);
        cyc(2);
        chk(irq, 1);
        rdchk(EVS, 32'h1);
        bus(1, CTRL, 32'h0);
        bus(1, EVS, 32'h3);
        cyc(2);
        chk(osc, 0);
        chk(irq, 0);
        rdchk(EVS, 32'h0);
        rdchk(8'h3c, 32'h0);
        bus(1, CTRL, 32'h0b);
        stop_req <= 1'b1;
        cyc(60);
        chk(n_wake, 1);
        chk(n_check, 0);
        stop_req <= 1'b0;
        cyc(5);
        chk(wake, 0);
        bus(1, CTRL, 32'h07);
        stop_req <= 1'b1;
        cyc(60);
        chk(n_wake, 1);
        chk(n_check > 0, 1);
        hall_sel <= 3'h1;
        hall_ie <= 1'b1;
        hall_sense <= 3'h1;
        cyc(60);
        chk(n_wake, 2);
        hall_ie <= 1'b0;
        hall_sense <= 3'h0;
        bus(1, CTRL, 32'h13);
        cyc(60);
        chk(n_reset, 0);
        bus(1, CTRL, 32'h03);
        bus(0, CTRL, 0);
        chk(q & 32'h10, 32'h10);
        bus(1, CTRL, 32'h31);
        stop_req <= 1'b0;
        cyc(45);
        chk(n_reset, 1);
        repeat (4)
        begin
            cyc(25);
            bus(1, CTRL, 32'h31);
        end
        chk(n_reset, 1);
        resetn_in <= 1'b0;
        cyc(2);
        resetn_in <= 1'b1;
        rdchk(CTRL, 32'h0);
        chk(sys_rst, 0);
        complete_run();
    end
endmodule : autonomous_watchdog_ctrl_tb_top
